/* hdl/stl_pkg.sv */
/*
  package for the skip-test and timer one load decoder.
  assumes a 10-bit instruction word and 4-bit data path.
*/
package stl_pkg;
  localparam int unsigned IW = 10;
  // opcode patterns
  localparam logic [9:0] OPC_SKIP_MEM_MASK  = 10'h3fc;
  localparam logic [9:0] OPC_SKIP_MEM       = 10'h020;
  localparam logic [9:0] OPC_SKIP_CARRY     = 10'h02f;
  localparam logic [9:0] OPC_SKIP_PORT      = 10'h02b;
  localparam logic [9:0] OPC_LOAD_TIMER_ONE = 10'h230;
  localparam int unsigned BIT_SEL_LSB = 0;
  localparam int unsigned BIT_SEL_W   = 2;
  localparam int unsigned PORT_SEL_W  = 3;
  localparam int unsigned NIB_W       = 4;
  localparam int unsigned PORT_W      = 8;

  typedef struct packed {
    logic [9:0] opcode;
    logic       valid;
  } stl_instr_t;

  typedef struct packed {
    logic [7:0] value;
    logic       load;
  } stl_timer_load_t;

  typedef enum logic [1:0] {
    STL_RUN       = 2'b00,
    STL_PORT_WAIT = 2'b01,
    STL_SKIPPING  = 2'b10
  } stl_state_t;
endpackage

/* hdl/stl_decoder.sv */
/*
  skip-test and timer one load execution logic of a 4-bit core.
  assumes the sequencer presents one instruction word per valid cycle,
  that the carry flag, memory word and index register come from the same
  clock domain, that port lines are pins, and that the sequencer obeys
  skip_active.
*/
// Summary of operation
// - memory bit zero at immediate index skips next
// - carry zero skips next; carry left unchanged
// - port line indexed by register zero skips
// - port test takes two words, two cycles
// - second register loads timer and reload high
// - accumulator loads low nibbles; one cycle
`timescale 1ns/1ps
module stl_decoder
(
  input  wire logic                clk,           // 250 MHz instruction clock
  input  wire logic                rst_n,         // synchronous reset, active low
  input  wire stl_pkg::stl_instr_t instr,         // fetched instruction word
  input  wire logic [3:0]          mem_word,      // data memory word at memory_pointer
  input  wire logic                carry_flag,    // carry flag of the core
  input  wire logic [3:0]          index_reg,     // index register
  input  wire logic [7:0]          port_lines,    // port input pins, asynchronous
  input  wire logic [3:0]          accumulator,   // accumulator
  input  wire logic [3:0]          reg_b,         // second working register
  output logic                     suppress,      // current word must take no effect
  output logic                     skip_active,   // current valid word is suppressed; same as suppress
  output logic                     busy,          // port test second cycle
  output stl_pkg::stl_timer_load_t timer_one_load, // counter load bus
  output logic [7:0]               timer_one_reload // reload register
);
  import stl_pkg::*;

  stl_state_t state_r;
  stl_state_t state_nxt;
  logic       is_mem;
  logic       is_carry;
  logic       is_port;
  logic       is_load;
  logic       live;
  logic       port_bit_r;
  logic [7:0] pair_value;
  logic [PORT_W-1:0]     port_sync1_r;
  logic [PORT_W-1:0]     port_sync2_r;
  logic [BIT_SEL_W-1:0]  mem_bit_sel;
  logic [PORT_SEL_W-1:0] port_sel;

  assign live     = instr.valid && state_r != STL_SKIPPING;
  assign is_mem   = live && state_r == STL_RUN
                    && (instr.opcode & OPC_SKIP_MEM_MASK) == OPC_SKIP_MEM;
  assign is_carry = live && state_r == STL_RUN && instr.opcode == OPC_SKIP_CARRY;
  assign is_port  = live && state_r == STL_RUN && instr.opcode == OPC_SKIP_PORT;
  assign is_load  = live && state_r == STL_RUN && instr.opcode == OPC_LOAD_TIMER_ONE;
  assign pair_value = {reg_b, accumulator};
  assign mem_bit_sel = instr.opcode[BIT_SEL_LSB +: BIT_SEL_W];
  assign port_sel    = index_reg[PORT_SEL_W-1:0];
  assign suppress = state_r == STL_SKIPPING;
  assign busy     = state_r == STL_PORT_WAIT;
  assign skip_active = state_r == STL_SKIPPING;

  // port lines are pins: two stages before any logic reads them, so a test
  // sees the pin level of two clocks earlier
  always_ff @(posedge clk) begin
    port_sync1_r <= port_lines;
    port_sync2_r <= port_sync1_r;
  end

  // index above seven is undefined; only the low three bits are used
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_bit_r <= 1'b1;
    end else if (is_port) begin
      port_bit_r <= port_sync2_r[port_sel];
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      STL_RUN: begin
        if (is_mem && !mem_word[mem_bit_sel]) begin
          state_nxt = STL_SKIPPING;
        end else if (is_carry && !carry_flag) begin
          state_nxt = STL_SKIPPING;
        end else if (is_port) begin
          state_nxt = STL_PORT_WAIT;
        end
      end
      STL_PORT_WAIT: begin
        // the second word is an operand slot and is never decoded
        if (instr.valid) begin
          state_nxt = port_bit_r ? STL_RUN : STL_SKIPPING;
        end
      end
      STL_SKIPPING: begin
        if (instr.valid) begin
          state_nxt = STL_RUN;
        end
      end
      default: state_nxt = STL_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= STL_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // carry is never written here, so a skip leaves it untouched
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_one_load   <= '0;
      timer_one_reload <= 8'h00;
    end else begin
      timer_one_load.load <= is_load;
      if (is_load) begin
        timer_one_load.value <= pair_value;
        timer_one_reload     <= pair_value;
      end
    end
  end

  property p_mem_skip;
    @(posedge clk) disable iff (!rst_n)
      (is_mem && !mem_word[mem_bit_sel]) |=> skip_active;
  endproperty
  a_mem_skip: assert property (p_mem_skip) else $error("memory bit skip missed");

  property p_mem_exec;
    @(posedge clk) disable iff (!rst_n)
      (is_mem && mem_word[mem_bit_sel]) |=> !skip_active;
  endproperty
  a_mem_exec: assert property (p_mem_exec) else $error("memory bit spurious skip");

  property p_carry_skip;
    @(posedge clk) disable iff (!rst_n)
      is_carry |=> (skip_active == !$past(carry_flag));
  endproperty
  a_carry_skip: assert property (p_carry_skip) else $error("carry skip wrong");

  property p_port_two;
    @(posedge clk) disable iff (!rst_n)
      is_port |=> busy;
  endproperty
  a_port_two: assert property (p_port_two) else $error("port test not two cycles");

  property p_port_skip;
    @(posedge clk) disable iff (!rst_n)
      (is_port && !port_sync2_r[port_sel]) ##1 (busy && instr.valid) |=> skip_active;
  endproperty
  a_port_skip: assert property (p_port_skip) else $error("port skip missed");

  property p_port_exec;
    @(posedge clk) disable iff (!rst_n)
      (is_port && port_sync2_r[port_sel]) ##1 (busy && instr.valid) |=> !skip_active;
  endproperty
  a_port_exec: assert property (p_port_exec) else $error("port spurious skip");

  property p_load_pair;
    @(posedge clk) disable iff (!rst_n)
      is_load |=> (timer_one_load.load && timer_one_load.value == $past(pair_value)
                   && timer_one_reload == $past(pair_value));
  endproperty
  a_load_pair: assert property (p_load_pair) else $error("timer one load wrong");

  property p_load_one;
    @(posedge clk) disable iff (!rst_n)
      is_load |=> ##1 (!timer_one_load.load || $past(is_load));
  endproperty
  a_load_one: assert property (p_load_one) else $error("timer load pulse stretched");

  property p_skip_suppress;
    @(posedge clk) disable iff (!rst_n)
      (skip_active && instr.valid) |-> (suppress && !is_load) ##1 !suppress;
  endproperty
  a_skip_suppress: assert property (p_skip_suppress) else $error("skip not one word");

  // reset alone must idle every output, so this one has no disable
  property p_reset_idle;
    @(posedge clk)
      !rst_n |=> (!skip_active && !busy && !timer_one_load.load
                  && timer_one_reload == 8'h00);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset left outputs active");

  // sampled reset in the antecedent: the edge that applies a reset is no violation
  property p_skip_hold;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && skip_active && !instr.valid) |=> skip_active;
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skip dropped before a word");

  property p_port_release;
    @(posedge clk) disable iff (!rst_n)
      (busy && instr.valid) |=> !busy;
  endproperty
  a_port_release: assert property (p_port_release) else $error("port wait too long");

  property p_skip_no_load;
    @(posedge clk) disable iff (!rst_n)
      suppress |=> !timer_one_load.load;
  endproperty
  a_skip_no_load: assert property (p_skip_no_load) else $error("skipped load took effect");

  property p_busy_no_load;
    @(posedge clk) disable iff (!rst_n)
      busy |=> !timer_one_load.load;
  endproperty
  a_busy_no_load: assert property (p_busy_no_load) else $error("second word decoded");

  property p_reload_hold;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && !is_load) |=> $stable(timer_one_reload);
  endproperty
  a_reload_hold: assert property (p_reload_hold) else $error("reload moved without load");

  property p_value_hold;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && !is_load) |=> $stable(timer_one_load.value);
  endproperty
  a_value_hold: assert property (p_value_hold) else $error("value moved without load");
endmodule // stl_decoder

/* sim/tb_stl_decoder.sv */
/* bench for stl_decoder: skip tests and timer one load.
   assumes results show at the edge that takes the word, one edge after it is driven. */
`timescale 1ns/1ps
module tb_stl_decoder;
  import stl_pkg::*;
  logic            clk, rst_n, carry_flag, suppress, skip_active, busy;
  stl_instr_t      instr;
  stl_timer_load_t ld;
  logic [3:0]      mem_word, index_reg, accumulator, reg_b;
  logic [7:0]      port_lines, reload;
  int              bad_count, check_count;
  stl_decoder stl_decoder_i (.clk(clk), .rst_n(rst_n), .instr(instr), .mem_word(mem_word),
    .carry_flag(carry_flag), .index_reg(index_reg), .port_lines(port_lines),
    .accumulator(accumulator), .reg_b(reg_b), .suppress(suppress),
    .skip_active(skip_active), .busy(busy), .timer_one_load(ld), .timer_one_reload(reload));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // present one word; sample at the following falling edge
  task automatic drv(input logic [9:0] op);
    @(posedge clk);
    instr <= '{opcode: op, valid: 1'b1};
    @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_carry;
    for (int c = 0; c < 2; c++) begin
      @(posedge clk) carry_flag <= c[0];
      drv(OPC_SKIP_CARRY);
      drv(10'h000);
      chk({7'h00, skip_active}, {7'h00, ~c[0]});
      chk({7'h00, suppress}, {7'h00, ~c[0]});
      drv(10'h000);
      chk({7'h00, suppress}, 8'h00);
    end
  endtask
  task automatic t_mem;
    @(posedge clk) mem_word <= 4'h6;
    for (int j = 0; j < 4; j++) begin
      drv(OPC_SKIP_MEM | 10'(j));
      drv(10'h000);
      chk({7'h00, suppress}, {7'h00, ~mem_word[j]});
      drv(10'h000);
    end
  endtask
  task automatic t_port;
    @(posedge clk) port_lines <= 8'h5a;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) index_reg <= 4'(k);
      drv(OPC_SKIP_PORT);
      drv(OPC_LOAD_TIMER_ONE);
      chk({7'h00, busy}, 8'h01);
      drv(10'h000);
      chk({7'h00, suppress}, {7'h00, ~port_lines[k]});
      chk({7'h00, ld.load}, 8'h00);
      drv(10'h000);
    end
  endtask
  task automatic t_load;
    @(posedge clk) begin
      accumulator <= 4'h3;
      reg_b       <= 4'hc;
      carry_flag  <= 1'b0;
    end
    drv(OPC_LOAD_TIMER_ONE);
    drv(10'h000);
    chk({7'h00, ld.load}, 8'h01);
    chk(ld.value, 8'hc3);
    chk(reload, 8'hc3);
    drv(10'h000);
    chk({7'h00, ld.load}, 8'h00);
    // a skipped load must leave the reload register alone
    @(posedge clk) accumulator <= 4'h9;
    drv(OPC_SKIP_CARRY);
    drv(OPC_LOAD_TIMER_ONE);
    drv(10'h000);
    chk({7'h00, ld.load}, 8'h00);
    chk(reload, 8'hc3);
  endtask
  // skip held over idle cycles, then a reset in mid-run
  task automatic t_reset;
    @(posedge clk) carry_flag <= 1'b0;
    drv(OPC_SKIP_CARRY);
    @(posedge clk) instr <= '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({7'h00, skip_active}, 8'h01);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    @(negedge clk);
    chk({6'h00, suppress, busy}, 8'h00);
    chk(reload, 8'h00);
  endtask
  initial begin
    {rst_n, carry_flag, mem_word, index_reg, accumulator, reg_b, port_lines} = '0;
    instr = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(reload, 8'h00);
    t_carry();
    t_mem();
    t_port();
    t_load();
    t_reset();
    wrap_up();
  end
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule // tb_stl_decoder
